/* File: logic/debug_match_pkg.sv */
/*
 * shared constants and carriers for the debug match unit: register map,
 * field positions, sequencer state codes and cpu-side bus structs.
 * assumes a 32-bit apb slave and a cpu with a 24-bit byte address space.
 */
`default_nettype none
package debug_match_pkg;
   // ==========================================================
   // register byte offsets (word aligned)
   localparam logic [7:0] OFS_CTRL1 = 8'h00; // first_debug_control_reg
   localparam logic [7:0] OFS_RANGE = 8'h04; // range_control_reg
   localparam logic [7:0] OFS_CTL_A = 8'h08; // comparator a control
   localparam logic [7:0] OFS_ADR_A = 8'h0C; // comparator a address
   localparam logic [7:0] OFS_CTL_B = 8'h10;
   localparam logic [7:0] OFS_ADR_B = 8'h14;
   localparam logic [7:0] OFS_CTL_D = 8'h18;
   localparam logic [7:0] OFS_ADR_D = 8'h1C;
   localparam logic [7:0] OFS_DATA_A = 8'h20; // data_byte_compare_0..3
   localparam logic [7:0] OFS_MASK_A = 8'h24; // per-bit mask, 1 = compared
   localparam logic [7:0] OFS_SEQ = 8'h28; // event target states
   localparam logic [7:0] OFS_STATUS = 8'h2C; // read only
   // ==========================================================
   // first_debug_control_reg bits
   localparam int ARM_BIT = 0;
   localparam int FORCE_FINAL_BIT = 1; // force_final_bit, self clearing
   localparam int EXT_EN_BIT = 2;
   localparam int BRK_EN_BIT = 3;
   // comparator control bits
   localparam int CMP_EN_BIT = 0;
   localparam int DIR_SEL_BIT = 3; // 0 = writes, 1 = reads
   localparam int QUALIFY_BIT = 2; // access_type_qualify
   localparam int OPCODE_SEL_BIT = 5; // opcode_select_bit
   localparam int RANGE_EN_BIT = 0;
   localparam int SEQ_FIELD_W = 3; // one target per event source
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // ==========================================================
   // access sizes
   localparam logic [1:0] SIZE_8 = 2'h0;
   localparam logic [1:0] SIZE_16 = 2'h1;
   localparam logic [1:0] SIZE_32 = 2'h2;
   // sequencer states; idle_state is the disarmed rest point
   typedef enum logic [2:0] {
      IDLE_STATE = 3'b000,
      STATE_1 = 3'b001,
      STATE_2 = 3'b010,
      STATE_3 = 3'b011,
      FINAL_STATE = 3'b100
   } seq_state_type;
   // cpu data access, data right aligned, first byte most significant
   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] size;
      logic [23:0] addr;
      logic [31:0] data;
   } data_access_type;
   // opcode reaching the execution stage
   typedef struct packed {
      logic valid;
      logic [23:0] pc;
   } opcode_exec_type;
endpackage
`default_nettype wire

/* File: logic/debug_match_unit.sv */
/*
 * debug_match_unit: three address comparators (a, b, d; a also compares
 * data), a state sequencer and an apb register file.
 * assumes cpu buses on sys_clk_i, word-crossing accesses presented whole in one cycle,
 * and an asynchronous external event pin.
 */
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module debug_match_unit
   import debug_match_pkg::*;
(
   input wire logic sys_clk_i, // 100 MHz cpu clock
   input wire logic rst_i, // async, active high
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire data_access_type data_access_i, // cpu data bus
   input wire opcode_exec_type opcode_exec_i, // cpu execution stage
   input wire logic ext_event_i, // asynchronous pin
   output logic [3:0] match_o, // channel pulses, bit 2 unused
   output logic breakpoint_o, // one-cycle request to the cpu
   output logic armed_o
);
   // ==========================================================
   // helper functions
   // number of bytes of an access
   function automatic logic [2:0] nbytes(input logic [1:0] size);
      case (size)
         SIZE_8: nbytes = 3'd1;
         SIZE_16: nbytes = 3'd2;
         default: nbytes = 3'd4;
      endcase
   endfunction
   // true when the byte at ref lies inside the access span
   function automatic logic span_hit(input logic [23:0] base, input logic [1:0] size,
                                     input logic [23:0] ref_addr);
      logic [23:0] off;
      off = ref_addr - base; // wraps, so one compare is enough
      span_hit = off < {21'h0, nbytes(size)};
   endfunction
   // lane based data compare of comparator a
   function automatic logic data_hit(input data_access_type a, input logic [31:0] ref_word,
                                     input logic [31:0] mask);
      logic [3:0] seen;
      logic ok;
      logic [1:0] lane;
      logic [7:0] got;
      logic [7:0] want;
      logic [7:0] msk;
      logic [2:0] n;
      seen = 4'h0;
      ok = 1'b1;
      n = nbytes(a.size);
      for (int k = 0; k < 4; k++) begin
         if (k < int'(n)) begin
            // lane wraps to 0 past lane 3, so a spill uses byte register 0
            lane = 2'(int'(a.addr[1:0]) + k);
            got = 8'(a.data >> (8 * (int'(n) - 1 - k)));
            want = 8'(ref_word >> (8 * (3 - int'(lane))));
            msk = 8'(mask >> (8 * (3 - int'(lane))));
            if (((got ^ want) & msk) != 8'h00) begin
               ok = 1'b0;
            end
            seen[lane] = 1'b1;
         end
      end
      // a compared lane that the access never touched cannot match
      for (int l = 0; l < 4; l++) begin
         if ((8'(mask >> (8 * (3 - l))) != 8'h00) && !seen[l]) begin
            ok = 1'b0;
         end
      end
      data_hit = ok;
   endfunction
   // direction qualification, shared by all comparators
   function automatic logic dir_ok(input logic [7:0] ctl, input logic wr);
      dir_ok = !ctl[QUALIFY_BIT] || (ctl[DIR_SEL_BIT] == !wr);
   endfunction
   // exact match of one comparator
   function automatic logic exact_hit(input logic [7:0] ctl, input logic [23:0] cadr,
                                      input data_access_type a, input opcode_exec_type o);
      if (!ctl[CMP_EN_BIT]) begin
         exact_hit = 1'b0;
      end else if (ctl[OPCODE_SEL_BIT]) begin
         exact_hit = o.valid && (o.pc == cadr);
      end else begin
         exact_hit = a.valid && span_hit(a.addr, a.size, cadr) && dir_ok(ctl, a.write);
      end
   endfunction

   // ==========================================================
   // registers
   logic arm_q; // armed flag
   logic ext_en_q; // external event may move the sequencer
   logic brk_en_q; // final state raises a breakpoint
   logic force_q; // force_final_bit request, one cycle
   logic range_en_q; // a/b pair in inside-range mode
   logic [7:0] ctl_a_q, ctl_b_q, ctl_d_q;
   logic [23:0] adr_a_q, adr_b_q, adr_d_q;
   logic [31:0] data_a_q; // data_byte_compare_0 in bits 31:24
   logic [31:0] mask_a_q; // 1 = bit compared
   logic [4*SEQ_FIELD_W-1:0] seq_q; // targets: match0, match1, match3, ext
   seq_state_type state_q;
   logic [3:0] match_q;
   logic brk_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;

   // ==========================================================
   // apb slave, one wait state so read data comes from a flop
   logic apb_take; // first access cycle
   logic apb_done; // completing edge
   logic mapped;
   logic [31:0] rd_word;
   assign apb_take = psel_i && penable_i && !pready_q;
   assign apb_done = psel_i && penable_i && pready_q;
   // read mux and decode
   always_comb begin
      mapped = 1'b1;
      rd_word = RESET_WORD;
      case (paddr_i)
         OFS_CTRL1: rd_word = {28'h0, brk_en_q, ext_en_q, 1'b0, arm_q};
         OFS_RANGE: rd_word = {31'h0, range_en_q};
         OFS_CTL_A: rd_word = {24'h0, ctl_a_q};
         OFS_ADR_A: rd_word = {8'h0, adr_a_q};
         OFS_CTL_B: rd_word = {24'h0, ctl_b_q};
         OFS_ADR_B: rd_word = {8'h0, adr_b_q};
         OFS_CTL_D: rd_word = {24'h0, ctl_d_q};
         OFS_ADR_D: rd_word = {8'h0, adr_d_q};
         OFS_DATA_A: rd_word = data_a_q;
         OFS_MASK_A: rd_word = mask_a_q;
         OFS_SEQ: rd_word = {20'h0, seq_q};
         OFS_STATUS: rd_word = {27'h0, arm_q, 1'b0, state_q};
         default: mapped = 1'b0; // unmapped: error, reads zero
      endcase
   end
   // answer flops
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= RESET_WORD;
      end else begin
         pready_q <= apb_take;
         pslverr_q <= apb_take && !mapped;
         if (apb_take && !pwrite_i) begin
            prdata_q <= rd_word;
         end
      end
   end
   logic wr_en; // write at the completing edge
   logic cfg_wr; // comparator set-up only while disarmed
   assign wr_en = apb_done && pwrite_i && mapped;
   assign cfg_wr = wr_en && !arm_q;

   // ==========================================================
   // comparator configuration
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_a_q <= 8'h00;
         ctl_b_q <= 8'h00;
         ctl_d_q <= 8'h00;
         adr_a_q <= 24'h00_0000;
         adr_b_q <= 24'h00_0000;
         adr_d_q <= 24'h00_0000;
         data_a_q <= RESET_WORD;
         mask_a_q <= RESET_WORD;
         range_en_q <= 1'b0;
         seq_q <= '0;
      end else if (cfg_wr) begin
         case (paddr_i)
            OFS_CTL_A: ctl_a_q <= pwdata_i[7:0];
            OFS_ADR_A: adr_a_q <= pwdata_i[23:0];
            OFS_CTL_B: ctl_b_q <= pwdata_i[7:0];
            OFS_ADR_B: adr_b_q <= pwdata_i[23:0];
            OFS_CTL_D: ctl_d_q <= pwdata_i[7:0];
            OFS_ADR_D: adr_d_q <= pwdata_i[23:0];
            OFS_DATA_A: data_a_q <= pwdata_i;
            OFS_MASK_A: mask_a_q <= pwdata_i;
            OFS_RANGE: range_en_q <= pwdata_i[RANGE_EN_BIT];
            OFS_SEQ: seq_q <= pwdata_i[4*SEQ_FIELD_W-1:0];
            default: ; // status and control handled elsewhere
         endcase
      end
   end

   // ==========================================================
   // external event pin: three flops, change once stages 2 and 3 agree
   logic ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;
   logic ext_rise;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
         ext_lvl_q <= 1'b0;
      end else begin
         ext_s1_q <= ext_event_i;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         if (ext_s2_q == ext_s3_q) begin
            ext_lvl_q <= ext_s3_q; // filters one-cycle glitches
         end
      end
   end
   assign ext_rise = (ext_s2_q == ext_s3_q) && ext_s3_q && !ext_lvl_q;

   // ==========================================================
   // match evaluation
   logic hit_a, hit_b, hit_d, hit_rng;
   logic [2:0] nb;
   logic [23:0] last_byte;
   assign nb = nbytes(data_access_i.size);
   assign last_byte = data_access_i.addr + {21'h0, nb} - 24'h00_0001;
   // data compare applies only in data mode; all-clear mask means address only
   assign hit_a = exact_hit(ctl_a_q, adr_a_q, data_access_i, opcode_exec_i) &&
                  (ctl_a_q[OPCODE_SEL_BIT] || data_hit(data_access_i, data_a_q, mask_a_q));
   assign hit_b = exact_hit(ctl_b_q, adr_b_q, data_access_i, opcode_exec_i);
   assign hit_d = exact_hit(ctl_d_q, adr_d_q, data_access_i, opcode_exec_i);
   // inside range uses comparator a set-up; b only gives the upper bound
   always_comb begin
      if (!ctl_a_q[CMP_EN_BIT]) begin
         hit_rng = 1'b0;
      end else if (ctl_a_q[OPCODE_SEL_BIT]) begin
         hit_rng = opcode_exec_i.valid && (opcode_exec_i.pc >= adr_a_q) && (opcode_exec_i.pc <= adr_b_q);
      end else begin
         hit_rng = data_access_i.valid && dir_ok(ctl_a_q, data_access_i.write) &&
                   (data_access_i.addr <= adr_b_q) && (last_byte >= adr_a_q) &&
                   data_hit(data_access_i, data_a_q, mask_a_q);
      end
   end
   // registered one-cycle pulses, only while armed
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         match_q <= 4'h0;
      end else if (!arm_q) begin
         match_q <= 4'h0;
      end else begin
         match_q[0] <= range_en_q ? hit_rng : hit_a;
         match_q[1] <= range_en_q ? 1'b0 : hit_b;
         match_q[2] <= 1'b0;
         match_q[3] <= hit_d;
      end
   end

   // ==========================================================
   // state sequencer; a match is an event only, data is never rechecked
   logic [SEQ_FIELD_W-1:0] tgt; // chosen target code, 0 = no move
   always_comb begin
      tgt = '0;
      if (ext_en_q && ext_rise) begin
         tgt = seq_q[3*SEQ_FIELD_W +: SEQ_FIELD_W];
      end else if (match_q[3]) begin
         tgt = seq_q[2*SEQ_FIELD_W +: SEQ_FIELD_W];
      end else if (match_q[1]) begin
         tgt = seq_q[SEQ_FIELD_W +: SEQ_FIELD_W];
      end else if (match_q[0]) begin
         tgt = seq_q[0 +: SEQ_FIELD_W];
      end
   end
   logic arm_wr; // software write of ctrl1
   assign arm_wr = wr_en && (paddr_i == OFS_CTRL1);
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= IDLE_STATE;
      end else begin
         case (state_q)
            IDLE_STATE: begin
               if (arm_wr && pwdata_i[ARM_BIT]) begin
                  state_q <= STATE_1;
               end
            end
            STATE_1, STATE_2, STATE_3: begin
               if (!arm_q) begin
                  state_q <= IDLE_STATE; // software disarm
               end else if (force_q) begin
                  state_q <= FINAL_STATE;
               end else if (tgt >= SEQ_FIELD_W'(FINAL_STATE)) begin
                  state_q <= FINAL_STATE;
               end else if (tgt != '0) begin
                  state_q <= seq_state_type'(tgt);
               end
            end
            FINAL_STATE: state_q <= IDLE_STATE;
            default: state_q <= IDLE_STATE;
         endcase
      end
   end
   // control register and breakpoint
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         arm_q <= 1'b0;
         ext_en_q <= 1'b0;
         brk_en_q <= 1'b0;
         force_q <= 1'b0;
         brk_q <= 1'b0;
      end else begin
         force_q <= arm_wr && pwdata_i[FORCE_FINAL_BIT] && arm_q;
         brk_q <= (state_q == FINAL_STATE) && brk_en_q;
         if (state_q == FINAL_STATE) begin
            arm_q <= 1'b0; // hardware disarm wins over a write
         end else if (arm_wr) begin
            arm_q <= pwdata_i[ARM_BIT];
         end
         if (arm_wr) begin
            ext_en_q <= pwdata_i[EXT_EN_BIT];
            brk_en_q <= pwdata_i[BRK_EN_BIT];
         end
      end
   end
   assign match_o = match_q;
   assign breakpoint_o = brk_q;
   assign armed_o = arm_q;
   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_idle_no_match: assert property (!arm_q |=> match_q == 4'h0)
      else $error("match while disarmed");
   a_final_to_idle: assert property (state_q == FINAL_STATE |=> state_q == IDLE_STATE && !arm_q)
      else $error("final state did not disarm");
   a_break_follows: assert property (state_q == FINAL_STATE && brk_en_q |=> brk_q ##1 !brk_q)
      else $error("breakpoint not a single pulse");
   a_force_final: assert property (force_q && state_q inside {STATE_1, STATE_2, STATE_3} && arm_q
      |=> state_q == FINAL_STATE)
      else $error("force did not reach final");
   a_opcode_match: assert property (arm_q && !range_en_q && ctl_a_q[CMP_EN_BIT] && ctl_a_q[OPCODE_SEL_BIT]
      && opcode_exec_i.valid && opcode_exec_i.pc == adr_a_q |=> match_q[0])
      else $error("opcode match missed");
   a_dir_block: assert property (arm_q && !range_en_q && ctl_a_q[QUALIFY_BIT] && !ctl_a_q[OPCODE_SEL_BIT]
      && data_access_i.write == ctl_a_q[DIR_SEL_BIT] |=> !match_q[0])
      else $error("direction qualifier ignored");
   a_range_mute: assert property (range_en_q |=> !match_q[1] && !match_q[2])
      else $error("channel 1 active in range mode");
   a_apb_wait: assert property (apb_take |=> pready_q ##1 !pready_q)
      else $error("apb answer timing wrong");
   a_byte8_full: assert property (arm_q && !range_en_q && mask_a_q == 32'hFFFF_FFFF
      && !ctl_a_q[OPCODE_SEL_BIT] && data_access_i.size != SIZE_32 |=> !match_q[0])
      else $error("partial access matched full compare");
   a_state_legal: assert property (arm_q && state_q == IDLE_STATE |=> state_q != IDLE_STATE || !arm_q)
      else $error("armed but idle");
   c_break: cover property (brk_q);
   c_ext_event: cover property (ext_en_q && ext_rise && state_q != IDLE_STATE);
   c_state3: cover property (state_q == STATE_3);
   c_data_a: cover property (match_q[0] && mask_a_q != 32'h0000_0000);
endmodule // debug_match_unit
`default_nettype wire

/* File: sim/cpu_bus_model.sv */
/*
 * cpu bus model: drives one data access or one opcode execution pulse per
 * call. assumes one calling process and the unit's 100 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model
   import debug_match_pkg::*;
(
   input wire logic sys_clk_i, // cpu clock
   output var data_access_type data_o, // data bus toward the unit
   output var opcode_exec_type opcode_o // execution stage toward the unit
);
   // ======================================================
   // idle buses
   // quiet values at time zero
   initial begin
      data_o = '0;
      opcode_o = '0;
   end
   // ======================================================
   // transfers
   // one cycle per access, a word-crossing access included
   task automatic access(input logic w, input logic [1:0] sz, input logic [23:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      data_o <= '{1'b1, w, sz, a, d};
      @(posedge sys_clk_i);
      // released bus shows the inverse, so stale values never match
      data_o <= '{1'b0, ~w, sz, ~a, ~d};
   endtask
   // opcode reaching execution, a single-cycle pulse
   task automatic opcode(input logic [23:0] pc);
      @(posedge sys_clk_i);
      opcode_o <= '{1'b1, pc};
      @(posedge sys_clk_i);
      opcode_o <= '{1'b0, ~pc};
   endtask
endmodule // cpu_bus_model
`default_nettype wire

/* File: sim/test_debug_match_unit.sv */
/*
 * bench for debug_match_unit: apb master, cpu model, one task per scenario.
 * assumes apb answers within a few cycles and match pulses one cycle late.
 */
`timescale 1ns/1ns
`default_nettype none
module test_debug_match_unit;
   import debug_match_pkg::*;
   logic sys_clk_i, rst_i, psel, penable, pwrite, ext_ev, pready, pslverr, bp, armed, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] match;
   data_access_type dacc;
   opcode_exec_type opx;
   int error_cnt = 0;
   int cmp_count = 0;
   // ======================================================
   // clock and parts
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   debug_match_unit i_dut (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .paddr_i(paddr),
      .psel_i(psel),
      .penable_i(penable),
      .pwrite_i(pwrite),
      .pwdata_i(pwdata),
      .prdata_o(prdata),
      .pready_o(pready),
      .pslverr_o(pslverr),
      .data_access_i(dacc),
      .opcode_exec_i(opx),
      .ext_event_i(ext_ev),
      .match_o(match),
      .breakpoint_o(bp),
      .armed_o(armed)
   );
   cpu_bus_model i_cpu (
      .sys_clk_i(sys_clk_i),
      .data_o(dacc),
      .opcode_o(opx)
   );
   // ======================================================
   // report and compare
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic hang();
      error_cnt++;
      $display("MISMATCH at %0t: no answer in time", $time);
      end_of_test();
   endtask
   task automatic cmp(input logic [31:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // ======================================================
   // bus tasks
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp, "register read");
   endtask
   // match_o is looked at in the cycle after the access
   task automatic acc(input logic w, input logic [1:0] sz, input logic [23:0] a, input logic [31:0] d,
                      input logic [3:0] exp);
      i_cpu.access(w, sz, a, d);
      #1;
      cmp({28'h0, match}, {28'h0, exp}, "match after access");
   endtask
   task automatic opc(input logic [23:0] pc, input logic [3:0] exp);
      i_cpu.opcode(pc);
      #1;
      cmp({28'h0, match}, {28'h0, exp}, "match after opcode");
   endtask
   // breakpoint pulse of one cycle, unit disarmed after it
   task automatic wait_bp();
      int n;
      n = 0;
      while (bp !== 1'b1 && n < 10) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      if (n >= 10) hang();
      @(posedge sys_clk_i);
      #1;
      cmp({31'h0, bp}, 32'h0, "breakpoint width");
      cmp({31'h0, armed}, 32'h0, "armed after final");
   endtask
   // ======================================================
   // scenarios
   task automatic t_span();
      rdchk(OFS_CTRL1, RESET_WORD);
      apb(1'b0, 8'h30, 32'h0);
      cmp({31'h0, err}, 32'h1, "unmapped error");
      wr(OFS_CTL_A, 32'h1);
      wr(OFS_ADR_A, 32'h101);
      wr(OFS_MASK_A, 32'h0);
      wr(OFS_CTL_B, 32'h1);
      wr(OFS_ADR_B, 32'h202);
      wr(OFS_CTL_D, 32'h1);
      wr(OFS_ADR_D, 32'h303);
      acc(1'b0, SIZE_8, 24'h101, 32'h0, 4'h0);
      wr(OFS_CTRL1, 32'h1);
      rdchk(OFS_STATUS, 32'h11);
      wr(OFS_ADR_A, 32'h555);
      rdchk(OFS_ADR_A, 32'h101);
      acc(1'b0, SIZE_32, 24'h100, 32'h0, 4'h1);
      acc(1'b1, SIZE_16, 24'h100, 32'h0, 4'h1);
      acc(1'b0, SIZE_16, 24'h101, 32'h0, 4'h1);
      acc(1'b0, SIZE_8, 24'h100, 32'h0, 4'h0);
      acc(1'b0, SIZE_16, 24'h102, 32'h0, 4'h0);
      acc(1'b1, SIZE_8, 24'h202, 32'h0, 4'h2);
      acc(1'b0, SIZE_16, 24'h302, 32'h0, 4'h8);
      @(posedge sys_clk_i);
      #1;
      cmp({28'h0, match}, 32'h0, "match width");
      $display("exact span test done");
   endtask
   task automatic t_dir();
      for (int q = 0; q < 2; q++) begin
         wr(OFS_CTRL1, 32'h0);
         wr(OFS_CTL_A, q ? 32'hD : 32'h5);
         wr(OFS_CTRL1, 32'h1);
         acc(1'b1, SIZE_8, 24'h101, 32'h0, q ? 4'h0 : 4'h1);
         acc(1'b0, SIZE_8, 24'h101, 32'h0, q ? 4'h1 : 4'h0);
      end
      $display("direction test done");
   endtask
   task automatic t_opc();
      wr(OFS_CTRL1, 32'h0);
      wr(OFS_CTL_A, 32'h2D);
      wr(OFS_CTRL1, 32'h1);
      opc(24'h101, 4'h1);
      opc(24'h100, 4'h0);
      acc(1'b0, SIZE_8, 24'h101, 32'h0, 4'h0);
      $display("opcode test done");
   endtask
   task automatic t_data();
      wr(OFS_CTRL1, 32'h0);
      wr(OFS_CTL_A, 32'h1);
      wr(OFS_ADR_A, 32'h100);
      wr(OFS_DATA_A, 32'h1122_3344);
      wr(OFS_MASK_A, 32'hFFFF_FFFF);
      wr(OFS_CTRL1, 32'h1);
      acc(1'b0, SIZE_32, 24'h100, 32'h1122_3344, 4'h1);
      acc(1'b0, SIZE_32, 24'h100, 32'h1122_3345, 4'h0);
      acc(1'b0, SIZE_16, 24'h100, 32'h1122, 4'h0);
      wr(OFS_CTRL1, 32'h0);
      wr(OFS_ADR_A, 32'h101);
      wr(OFS_MASK_A, 32'h00FF_0000);
      wr(OFS_CTRL1, 32'h1);
      acc(1'b0, SIZE_8, 24'h101, 32'h22, 4'h1);
      acc(1'b1, SIZE_16, 24'h100, 32'h0022, 4'h1);
      acc(1'b0, SIZE_8, 24'h101, 32'h23, 4'h0);
      wr(OFS_CTRL1, 32'h0);
      wr(OFS_ADR_A, 32'h104);
      wr(OFS_MASK_A, 32'hFF00_0000);
      wr(OFS_CTRL1, 32'h1);
      acc(1'b0, SIZE_8, 24'h104, 32'h11, 4'h1);
      acc(1'b0, SIZE_16, 24'h103, 32'h0011, 4'h1);
      $display("data compare test done");
   endtask
   task automatic t_seq();
      wr(OFS_CTRL1, 32'h0);
      wr(OFS_CTL_A, 32'h1);
      wr(OFS_ADR_A, 32'h100);
      wr(OFS_MASK_A, 32'h0);
      wr(OFS_SEQ, 32'h5A);
      wr(OFS_CTRL1, 32'h1);
      acc(1'b0, SIZE_8, 24'h100, 32'h0, 4'h1);
      rdchk(OFS_STATUS, 32'h12);
      acc(1'b0, SIZE_8, 24'h202, 32'h0, 4'h2);
      rdchk(OFS_STATUS, 32'h13);
      acc(1'b0, SIZE_8, 24'h303, 32'h0, 4'h8);
      rdchk(OFS_STATUS, 32'h11);
      $display("sequencer test done");
   endtask
   task automatic t_final();
      wr(OFS_CTRL1, 32'h0);
      wr(OFS_SEQ, 32'h804);
      wr(OFS_CTRL1, 32'h9);
      acc(1'b0, SIZE_8, 24'h100, 32'h0, 4'h1);
      wait_bp();
      rdchk(OFS_STATUS, 32'h0);
      wr(OFS_CTRL1, 32'h9);
      wr(OFS_CTRL1, 32'hB);
      wait_bp();
      wr(OFS_CTRL1, 32'hD);
      ext_ev <= 1'b1;
      wait_bp();
      ext_ev <= 1'b0;
      $display("final state test done");
   endtask
   // inside range a..b on channel 0, channel 1 kept silent
   task automatic t_range();
      wr(OFS_CTRL1, 32'h0);
      wr(OFS_SEQ, 32'h0);
      wr(OFS_RANGE, 32'h1);
      wr(OFS_ADR_B, 32'h180);
      wr(OFS_CTRL1, 32'h1);
      acc(1'b0, SIZE_8, 24'h140, 32'h0, 4'h1);
      acc(1'b0, SIZE_16, 24'h180, 32'h0, 4'h1);
      acc(1'b0, SIZE_8, 24'h181, 32'h0, 4'h0);
      acc(1'b0, SIZE_8, 24'h0FF, 32'h0, 4'h0);
      $display("range test done");
   endtask
   // ======================================================
   // main sequence
   initial begin
      rst_i = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext_ev = 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_span();
      t_dir();
      t_opc();
      t_data();
      t_seq();
      t_final();
      t_range();
      end_of_test();
   end
endmodule // test_debug_match_unit
`default_nettype wire
